// ===== pkg/ssq_pkg.sv
// shared constants, carrier types and sequence functions for the stepper phase sequencer
`default_nettype none
package ssq_pkg;

    // register bus carrier
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ssq_bus_t;

    // four phase drive levels, one bit per output
    typedef struct packed {
        logic one;
        logic one_inv;
        logic two;
        logic two_inv;
    } ssq_phase_t;

    // run condition, gray coded along reset -> run -> off -> fault
    typedef enum logic [1:0] {
        SSQ_HELD  = 2'b00,
        SSQ_RUN   = 2'b01,
        SSQ_OFF   = 2'b11,
        SSQ_FAULT = 2'b10
    } ssq_state_t;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_POSITION = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PINS     = 8'h10;

    // status and mask bit positions
    localparam int EV_STEP    = 0;
    localparam int EV_FAULT   = 1;
    localparam int EV_RELEASE = 2;
    localparam int EV_W       = 3;

    // position register field positions
    localparam int POS_IDX_LSB   = 0;
    localparam int POS_PHASE_LSB = 4;
    localparam int POS_FAULT_BIT = 8;
    localparam int POS_STATE_LSB = 12;

    // reset values
    localparam logic [2:0]        INIT_POS   = 3'h0;
    localparam logic [EV_W-1:0]   MASK_RST   = 3'h0;
    localparam logic [DATA_W-1:0] COUNT_RST  = 32'h0000_0000;
    localparam ssq_phase_t        PHASE_OFF  = 4'h0;

    // drive pattern for each of the eight half-step positions
    function automatic ssq_phase_t ssq_pattern(input logic [2:0] pos);
        ssq_phase_t p;
        p = PHASE_OFF;
        case (pos)
            3'h0: p = 4'h9;
            3'h1: p = 4'h8;
            3'h2: p = 4'ha;
            3'h3: p = 4'h2;
            3'h4: p = 4'h6;
            3'h5: p = 4'h4;
            3'h6: p = 4'h5;
            3'h7: p = 4'h1;
            default: p = PHASE_OFF;
        endcase
        return p;
    endfunction : ssq_pattern

    // full step from an odd (single-phase) position lands on the next two-phase position
    function automatic logic [2:0] ssq_advance(input logic [2:0] pos,
                                               input logic       half,
                                               input logic       rev);
        logic [2:0] stride;
        stride = (half || pos[0]) ? 3'h1 : 3'h2;
        return rev ? 3'(pos - stride) : 3'(pos + stride);
    endfunction : ssq_advance

endpackage : ssq_pkg
`default_nettype wire

// ===== hdl/ssq_step_edge.sv
// step clock edge detector with edge selection
`timescale 1ns/1ps
`default_nettype none
module ssq_step_edge (
    input  wire logic mclk_in,
    input  wire logic nrst_in,
    input  wire logic step_clk_in,
    input  wire logic edge_select_in,
    output logic      rise_out,
    output logic      fall_out,
    output logic      step_out
);
    import ssq_pkg::*;

    logic prev;
    logic primed;

    // no edge is reported in the first cycle, so a high level at reset is not a step
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev   <= 1'b0;
            primed <= 1'b0;
        end else begin
            prev   <= step_clk_in;
            primed <= 1'b1;
        end
    end

    assign rise_out = primed && step_clk_in && !prev;
    assign fall_out = primed && !step_clk_in && prev;
    assign step_out = rise_out || (!edge_select_in && fall_out);

endmodule : ssq_step_edge
`default_nettype wire

// ===== hdl/ssq_sequencer.sv
// stepper phase sequencer top: sequence, gating, fault latch, registers and interrupt
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - edge select high: one step per rising step clock edge only.
// - edge select low: one step on each rising and falling edge.
// - excitation select low gives full step, high gives half step.
// - direction low steps forward, high steps in reverse order.
// - reset input low holds the sequence in its reset state.
// - leaving reset starts with phase one and phase two inverse on.
// - enable low forces all four phase outputs off.
// - enable high again resumes from the held position.
// - fault output low while a fault is latched, high otherwise.
// - steady step clock keeps the present pattern on the outputs.
// - faults latch outputs off until a reset input low pulse.
module ssq_sequencer (
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              step_clk_in,
    input  wire logic              excitation_select_in,
    input  wire logic              edge_select_in,
    input  wire logic              direction_in,
    input  wire logic              reset_n_in,
    input  wire logic              enable_in,
    input  wire logic              overcurrent_in,
    input  wire logic              overheat_in,
    input  wire ssq_pkg::ssq_bus_t bus_in,
    output logic [31:0]            rdata_out,
    output logic                   phase_one_out,
    output logic                   phase_one_inverse_out,
    output logic                   phase_two_out,
    output logic                   phase_two_inverse_out,
    output logic                   fault_n_out,
    output logic                   irq_out
);
    import ssq_pkg::*;

    // edge detection
    logic step_rise;
    logic step_fall;
    logic step_pulse;

    ssq_step_edge u_edge (
        .mclk_in        (mclk_in),
        .nrst_in        (nrst_in),
        .step_clk_in    (step_clk_in),
        .edge_select_in (edge_select_in),
        .rise_out       (step_rise),
        .fall_out       (step_fall),
        .step_out       (step_pulse)
    );

    // state
    logic [2:0]        pos;
    ssq_phase_t        phase;
    logic              fault_q;
    ssq_state_t        state;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [DATA_W-1:0] count;
    logic              reset_prev;

    // decode
    wire        detect     = overcurrent_in || overheat_in;
    wire        next_fault = reset_n_in && (fault_q || detect);
    wire        run        = reset_n_in && enable_in && !fault_q && !detect;
    wire        advance    = run && step_pulse;
    wire  [2:0] stepped    = ssq_advance(pos, excitation_select_in, direction_in);
    wire  [2:0] next_pos   = !reset_n_in ? INIT_POS : (advance ? stepped : pos);
    wire        drive_on   = enable_in && next_fault == 1'b0 && reset_n_in;
    wire ssq_phase_t next_phase = drive_on ? ssq_pattern(next_pos) : PHASE_OFF;
    wire  [DATA_W-1:0] next_count = !reset_n_in ? COUNT_RST :
                                    !advance ? count :
                                    direction_in ? count - 32'h1 : count + 32'h1;

    ssq_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            SSQ_HELD:  next_state = reset_n_in ? SSQ_RUN : SSQ_HELD;
            SSQ_RUN:   next_state = !reset_n_in ? SSQ_HELD :
                                    next_fault  ? SSQ_FAULT :
                                    !enable_in  ? SSQ_OFF : SSQ_RUN;
            SSQ_OFF:   next_state = !reset_n_in ? SSQ_HELD :
                                    next_fault  ? SSQ_FAULT :
                                    enable_in   ? SSQ_RUN : SSQ_OFF;
            SSQ_FAULT: next_state = !reset_n_in ? SSQ_HELD : SSQ_FAULT;
            default:   next_state = SSQ_HELD;
        endcase
    end

    // sequence and outputs
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pos        <= INIT_POS;
            phase      <= PHASE_OFF;
            fault_q    <= 1'b0;
            state      <= SSQ_HELD;
            count      <= COUNT_RST;
            reset_prev <= 1'b0;
        end else begin
            pos        <= next_pos;
            phase      <= next_phase;
            fault_q    <= next_fault;
            state      <= next_state;
            count      <= next_count;
            reset_prev <= reset_n_in;
        end
    end

    assign phase_one_out         = phase.one;
    assign phase_one_inverse_out = phase.one_inv;
    assign phase_two_out         = phase.two;
    assign phase_two_inverse_out = phase.two_inv;
    assign fault_n_out           = !fault_q;

    // register bus
    wire sel_status = bus_in.addr == OFF_STATUS;
    wire sel_mask   = bus_in.addr == OFF_MASK;
    wire sel_pos    = bus_in.addr == OFF_POSITION;
    wire sel_count  = bus_in.addr == OFF_COUNT;
    wire sel_pins   = bus_in.addr == OFF_PINS;

    // events; a set in the cycle of a write-one-to-clear wins
    wire [EV_W-1:0] events;
    assign events[EV_STEP]    = advance;
    assign events[EV_FAULT]   = next_fault && !fault_q;
    assign events[EV_RELEASE] = reset_n_in && !reset_prev;

    wire [EV_W-1:0] clr_bits    = (bus_in.wr && sel_status) ? bus_in.wdata[EV_W-1:0] : '0;
    wire [EV_W-1:0] next_status = (status & ~clr_bits) | events;
    wire [EV_W-1:0] next_mask   = (bus_in.wr && sel_mask) ? bus_in.wdata[EV_W-1:0] : mask;

    wire [DATA_W-1:0] pos_word = (DATA_W'(pos) << POS_IDX_LSB)
                               | (DATA_W'(phase) << POS_PHASE_LSB)
                               | (DATA_W'(fault_q) << POS_FAULT_BIT)
                               | (DATA_W'(state) << POS_STATE_LSB);
    wire [DATA_W-1:0] pin_word = {24'h0, overheat_in, overcurrent_in, enable_in, reset_n_in,
                                  direction_in, edge_select_in, excitation_select_in,
                                  step_clk_in};
    // unmapped addresses read as zero
    wire [DATA_W-1:0] read_mux = sel_status ? DATA_W'(status) :
                                 sel_mask   ? DATA_W'(mask) :
                                 sel_pos    ? pos_word :
                                 sel_count  ? count :
                                 sel_pins   ? pin_word : '0;
    wire [DATA_W-1:0] next_rdata = bus_in.rd ? read_mux : '0;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status    <= '0;
            mask      <= MASK_RST;
            rdata_out <= '0;
            irq_out   <= 1'b0;
        end else begin
            status    <= next_status;
            mask      <= next_mask;
            rdata_out <= next_rdata;
            irq_out   <= |(next_status & next_mask);
        end
    end

    // checks
    rise_only_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reset_n_in && edge_select_in && step_fall && !step_rise |=> pos == $past(pos))
        else $error("falling edge stepped with rising-only selection");

    both_edges_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !edge_select_in && step_fall && run |=> pos != $past(pos))
        else $error("falling edge did not step with both-edge selection");

    half_fwd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && excitation_select_in && !direction_in |=> pos == 3'($past(pos) + 3'h1))
        else $error("half step forward wrong");

    full_even_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && !excitation_select_in |=> !pos[0] && $countones(phase) == 2)
        else $error("full step left a single-phase pattern");

    reverse_dir_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && direction_in && excitation_select_in |=> pos == 3'($past(pos) - 3'h1))
        else $error("reverse half step wrong");

    reset_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !reset_n_in ##1 !reset_n_in |-> pos == INIT_POS && phase == PHASE_OFF)
        else $error("sequence moved while reset input low");

    release_init_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !reset_n_in ##1 (reset_n_in && enable_in && !detect && !step_pulse)
        |=> phase == 4'h9)
        else $error("first pattern after reset release wrong");

    enable_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !enable_in |=> phase == PHASE_OFF)
        else $error("outputs driven while disabled");

    disable_keep_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !enable_in && reset_n_in |=> pos == $past(pos))
        else $error("position lost while disabled");

    fault_flag_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reset_n_in && detect |=> !fault_n_out ##1 (!fault_n_out || !$past(reset_n_in)))
        else $error("fault output not low after detection");

    steady_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !step_rise && !step_fall && reset_n_in |=> pos == $past(pos) && count == $past(count))
        else $error("sequence moved with a steady step clock");

    fault_latch_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        fault_q && reset_n_in |=> fault_q && phase == PHASE_OFF)
        else $error("fault latch released without reset input pulse");

    irq_level_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        ##1 irq_out == |(status & mask))
        else $error("interrupt output disagrees with status and mask");

    full_fwd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && !excitation_select_in && !direction_in && !pos[0]
        |=> pos == 3'($past(pos) + 3'h2))
        else $error("full step forward did not move two positions");

    full_rev_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && !excitation_select_in && direction_in && !pos[0]
        |=> pos == 3'($past(pos) - 3'h2))
        else $error("full step reverse did not move two positions");

    full_odd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && !excitation_select_in && pos[0]
        |=> pos == ($past(direction_in) ? 3'($past(pos) - 3'h1) : 3'($past(pos) + 3'h1)))
        else $error("full step from a single-phase position missed the next pair");

    half_alt_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && excitation_select_in
        |=> $countones(phase) == ($past(pos[0]) ? 2 : 1))
        else $error("half step did not alternate one and two phases");

    mode_keep_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $changed(excitation_select_in) && reset_n_in && !step_pulse
        |=> pos == $past(pos))
        else $error("mode change moved the position");

    resume_pos_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !enable_in ##1 (enable_in && reset_n_in && !fault_q && !detect && !step_pulse)
        |=> pos == $past(pos) && phase != PHASE_OFF)
        else $error("enable return did not resume the held pattern");

    state_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state == SSQ_OFF
        |-> phase == PHASE_OFF)
        else $error("outputs driven in the disabled state");

    count_clear_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !reset_n_in
        |=> count == COUNT_RST && pos == INIT_POS)
        else $error("reset input low left count or position");

    reset_unlatch_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !reset_n_in
        |=> !fault_q && fault_n_out)
        else $error("reset input low did not clear the fault latch");

    fault_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reset_n_in && detect
        |=> phase == PHASE_OFF && !fault_n_out)
        else $error("detection did not turn the outputs off");

    fault_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        fault_q && reset_n_in && step_pulse
        |=> pos == $past(pos))
        else $error("step taken while faulted");

    state_fault_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        state == SSQ_FAULT
        |-> fault_q && !fault_n_out)
        else $error("fault state without the fault flag");

    count_fwd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && !direction_in
        |=> count == $past(count) + 32'h1)
        else $error("step count did not rise on a forward step");

    count_rev_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance && direction_in
        |=> count == $past(count) - 32'h1)
        else $error("step count did not fall on a reverse step");

    step_set_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        advance
        |=> status[EV_STEP])
        else $error("step event not recorded");

    fault_event_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reset_n_in && detect && !fault_q
        |=> status[EV_FAULT])
        else $error("fault event not recorded");

    release_event_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reset_n_in && !reset_prev
        |=> status[EV_RELEASE])
        else $error("reset release event not recorded");

    status_clear_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.wr && sel_status && bus_in.wdata[EV_STEP] && !advance
        |=> !status[EV_STEP])
        else $error("write one did not clear the step event");

    mask_write_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.wr && sel_mask
        |=> mask == $past(bus_in.wdata[EV_W-1:0]))
        else $error("mask write did not land");

    irq_mask_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        mask == '0 && !(bus_in.wr && sel_mask)
        |=> !irq_out)
        else $error("interrupt raised with every event masked");

    rdata_idle_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !bus_in.rd
        |=> rdata_out == '0)
        else $error("read data not zero outside a read");

    read_status_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.rd && sel_status
        |=> rdata_out == DATA_W'($past(status)))
        else $error("status read wrong");

    read_mask_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.rd && sel_mask
        |=> rdata_out == DATA_W'($past(mask)))
        else $error("mask read wrong");

    read_count_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.rd && sel_count
        |=> rdata_out == $past(count))
        else $error("count read wrong");

    read_pos_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.rd && sel_pos
        |=> rdata_out[POS_IDX_LSB +: 3] == $past(pos) && rdata_out[POS_FAULT_BIT] == $past(fault_q))
        else $error("position read wrong");

    read_unmapped_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_in.rd && !(sel_status || sel_mask || sel_pos || sel_count || sel_pins)
        |=> rdata_out == '0)
        else $error("unmapped read not zero");

endmodule : ssq_sequencer
`default_nettype wire

// ===== sim/ssq_host.sv
// host controller model: drives the step clock and direction levels
`timescale 1ns/1ps
`default_nettype none
module ssq_host (
    input  wire logic mclk_in,
    output logic      step_clk_out,
    output logic      direction_out
);
    initial begin
        step_clk_out = 1'b0;
        direction_out = 1'b0;
    end
    // direction settles two cycles before the step edge and holds three after it
    task automatic toggle(input logic dir);
        @(posedge mclk_in) direction_out <= dir;
        repeat (2) @(posedge mclk_in);
        step_clk_out <= ~step_clk_out;
        repeat (3) @(posedge mclk_in);
    endtask : toggle
endmodule : ssq_host
`default_nettype wire

// ===== sim/ssq_sequencer_test.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_sequencer_test;
    import ssq_pkg::*;
    logic            mclk, nrst, excit, edge_sel, rst_n, en, ocur, oheat, off;
    ssq_bus_t        bus;
    wire logic [31:0] rdata;
    wire logic       stp, dir, p1, p1n, p2, p2n, flt_n, irq;
    wire logic [3:0] ph = {p1, p1n, p2, p2n};
    int              err_total, samples_checked, pos;
    logic [3:0]      pat [8] = '{4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};

    ssq_host ssq_host_i (.mclk_in(mclk), .step_clk_out(stp), .direction_out(dir));
    ssq_sequencer ssq_sequencer_i (
        .mclk_in(mclk), .nrst_in(nrst), .step_clk_in(stp), .excitation_select_in(excit),
        .edge_select_in(edge_sel), .direction_in(dir), .reset_n_in(rst_n), .enable_in(en),
        .overcurrent_in(ocur), .overheat_in(oheat), .bus_in(bus), .rdata_out(rdata),
        .phase_one_out(p1), .phase_one_inverse_out(p1n), .phase_two_out(p2),
        .phase_two_inverse_out(p2n), .fault_n_out(flt_n), .irq_out(irq));

    always #5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one step clock level change; the model advances only on edges that count
    task automatic step(input logic d);
        logic counts;
        counts = !off && (!stp || !edge_sel);
        ssq_host_i.toggle(d);
        if (counts)
            pos = (pos + (d ? -1 : 1) * ((excit || pos[0]) ? 1 : 2) + 8) % 8;
        #1 chk(32'(ph), off ? 32'h0 : 32'(pat[pos]));
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd

    task automatic seq_restart;
        @(posedge mclk) rst_n <= 1'b0;
        @(posedge mclk) rst_n <= 1'b1;
        pos = 0;
        off = 1'b0;
        repeat (3) @(posedge mclk);
        #1 chk(32'(ph), 32'h9);
        chk(32'(flt_n), 32'h1);
    endtask : seq_restart

    task automatic t_reset;
        step(1'b0);
        step(1'b0);
        seq_restart();
    endtask : t_reset

    task automatic t_full;
        repeat (4) step(1'b0);
    endtask : t_full

    // mode change mid-sequence must carry on from the present position
    task automatic t_half;
        @(posedge mclk) excit <= 1'b1;
        edge_sel <= 1'b0;
        repeat (3) step(1'b1);
        @(posedge mclk) excit <= 1'b0;
        step(1'b0);
        step(1'b0);
        step(1'b1);
        repeat (20) @(posedge mclk);
        #1 chk(32'(ph), 32'(pat[pos]));
    endtask : t_half

    task automatic t_enable;
        @(posedge mclk) en <= 1'b0;
        off = 1'b1;
        repeat (2) step(1'b0);
        @(posedge mclk) en <= 1'b1;
        off = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(32'(ph), 32'(pat[pos]));
    endtask : t_enable

    task automatic t_fault;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk) {oheat, ocur} <= i ? 2'b10 : 2'b01;
            @(posedge mclk) {oheat, ocur} <= 2'b00;
            off = 1'b1;
            repeat (2) @(posedge mclk);
            #1 chk(32'(flt_n), 32'h0);
            step(1'b1);
            chk(32'(flt_n), 32'h0);
            seq_restart();
        end
    endtask : t_fault

    // masked event leaves irq low, unmasking raises it, write-one clears it
    task automatic t_regs;
        rd(OFF_STATUS, 32'h7);
        wr(OFF_STATUS, 32'h7);
        wr(OFF_MASK, 32'h0);
        step(1'b0);
        step(1'b0);
        #1 chk(32'(irq), 32'h0);
        rd(OFF_STATUS, 32'h1);
        rd(OFF_COUNT, 32'h2);
        rd(OFF_POSITION, 32'h1064);
        rd(OFF_PINS, 32'h30);
        wr(OFF_MASK, 32'h1);
        rd(OFF_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(OFF_STATUS, 32'h1);
        @(posedge mclk);
        #1 chk(32'(irq), 32'h0);
        rd(8'h40, 32'h0);
    endtask : t_regs

    task automatic stop_test;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        stop_test();
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        excit = 1'b0;
        edge_sel = 1'b1;
        rst_n = 1'b0;
        en = 1'b1;
        ocur = 1'b0;
        oheat = 1'b0;
        bus = '0;
        off = 1'b1;
        pos = 0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_full();
        t_half();
        t_enable();
        t_fault();
        t_regs();
        stop_test();
    end
endmodule : ssq_sequencer_test
`default_nettype wire
